// ===== include/rmsc_pkg.sv
package rmsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Operation codes presented by the decoder
  localparam logic [1:0] RMSC_OP_REAL = 2'h0;
  localparam logic [1:0] RMSC_OP_LONG = 2'h1;
  localparam logic [1:0] RMSC_OP_EXT = 2'h2;
  localparam logic [1:0] RMSC_OP_STR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Register group sizes per operation
  localparam logic [1:0] RMSC_GRP_REAL = 2'h1;
  localparam logic [1:0] RMSC_GRP_LONG = 2'h2;
  localparam logic [1:0] RMSC_GRP_EXT = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Exception bit positions, fault cause adds the reserved-operand bit on top
  localparam int RMSC_EXC_OVF = 0;
  localparam int RMSC_EXC_UNF = 1;
  localparam int RMSC_EXC_INV = 2;
  localparam int RMSC_EXC_INX = 3;
  localparam int RMSC_EXC_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Format constants
  localparam logic [14:0] RMSC_EXT_EMAX = 15'h7fff;
  localparam logic [14:0] RMSC_EXT_BIAS = 15'h3fff;
  localparam logic [14:0] RMSC_LONG_ADJ = 15'h3c00;
  localparam logic [14:0] RMSC_SGL_ADJ = 15'h3f80;
  localparam logic [17:0] RMSC_LONG_BIAS = 18'h003ff;
  localparam logic [17:0] RMSC_SGL_BIAS = 18'h0007f;
  localparam logic [17:0] RMSC_LONG_EMAX = 18'h007ff;
  localparam logic [17:0] RMSC_SGL_EMAX = 18'h000ff;
  localparam logic [15:0] RMSC_EXT_PAD = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and buffer shape
  localparam logic RMSC_RST_READY = 1'b1;
  localparam logic [1:0] RMSC_BUF_DEPTH = 2'h2;
  localparam int RMSC_BYTE_W = 8;

  typedef struct packed {
    logic [79:0] val;
    logic [RMSC_EXC_W-1:0] exc;
    logic rsv;
  } rmsc_wide_t;

  typedef struct packed {
    logic [63:0] val;
    logic [RMSC_EXC_W-1:0] exc;
  } rmsc_narrow_t;

  typedef enum logic {RMSC_ST_IDLE, RMSC_ST_RUN} rmsc_state_t;

endpackage

// ===== src/rmsc_top.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Long-real move uses a group of two consecutive general registers.
// - Extended-real move uses a group of three consecutive general registers.
// - Real and long-real convert to or from extended format across files.
// - Real to long-real only via an extended value, never directly.
// - Extended load from general registers drops upper 16 bits of word three.
// - Extended store to general registers zero-fills upper 16 bits of word three.
// - Extended move copies bits only and never raises an exception.
// - Real and long-real moves may raise floating-point exceptions.
// - Unnormal or denormal operand with normalizing mode set gives reserved-operand fault.
// - Each exception faults only when its own mask bit is clear.
// - Overflow when result magnitude exceeds destination format range.
// - Underflow when result magnitude is below destination format range.
// - Invalid operation when source is a signalling NaN.
// - Inexact when result cannot be held exactly.
// - String move copies consecutive bytes from source to destination address.
// - String length is a 32-bit byte count up to 2^32-1.
// - Overlap safe: copy downward when source not above destination, else upward.
module rmsc_top
  import rmsc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire logic [1:0] CMD_OP_I,
  input wire logic CMD_SRC_FP_I,
  input wire logic CMD_DST_FP_I,
  input wire logic [4:0] CMD_DST_REG_I,
  input wire logic [95:0] CMD_GR_DATA_I,
  input wire logic [79:0] CMD_FP_DATA_I,
  input wire logic CMD_NORM_MODE_I,
  input wire logic [RMSC_EXC_W-1:0] CMD_EXC_MASK_I,
  input wire logic [31:0] CMD_SRC_ADDR_I,
  input wire logic [31:0] CMD_DST_ADDR_I,
  input wire logic [31:0] CMD_LEN_I,
  output logic GR_WE_O,
  output logic [4:0] GR_WADDR_O,
  output logic [1:0] GR_WCNT_O,
  output logic [95:0] GR_WDATA_O,
  output logic FP_WE_O,
  output logic [4:0] FP_WADDR_O,
  output logic [79:0] FP_WDATA_O,
  output logic [RMSC_EXC_W-1:0] EXC_O,
  output logic FAULT_O,
  output logic [RMSC_EXC_W:0] FAULT_CAUSE_O,
  output logic DONE_O,
  output logic MEM_RD_REQ_O,
  output logic [31:0] MEM_RD_ADDR_O,
  input wire logic MEM_RD_ACK_I,
  input wire logic [RMSC_BYTE_W-1:0] MEM_RD_DATA_I,
  output logic MEM_WR_REQ_O,
  output logic [31:0] MEM_WR_ADDR_O,
  output logic [RMSC_BYTE_W-1:0] MEM_WR_DATA_O,
  input wire logic MEM_WR_ACK_I
);

  ////////////////////////////////////////////////////////////////////////////
  // Format helpers

  // Real or long real into extended; always exact
  function automatic rmsc_wide_t widen(input logic [63:0] b, input logic is_long,
                                       input logic norm);
    rmsc_wide_t r;
    logic s;
    logic [10:0] ex;
    logic [51:0] f;
    logic [14:0] adj;
    logic top;
    logic [14:0] e;
    logic [63:0] m;
    r = '0;
    if (is_long) begin
      s = b[63];
      ex = b[62:52];
      f = b[51:0];
      adj = RMSC_LONG_ADJ;
      top = (b[62:52] == 11'h7ff);
    end else begin
      s = b[31];
      ex = {3'h0, b[30:23]};
      f = {b[22:0], 29'h0};
      adj = RMSC_SGL_ADJ;
      top = (b[30:23] == 8'hff);
    end
    if (top) begin
      e = RMSC_EXT_EMAX;
      m = {1'b1, f, 11'h0};
      if ((f != 52'h0) && !f[51]) begin
        r.exc[RMSC_EXC_INV] = 1'b1;
        m[62] = 1'b1;
      end
    end else if (ex == 11'h0) begin
      e = (f == 52'h0) ? 15'h0 : adj + 15'h1;
      m = {1'b0, f, 11'h0};
      r.rsv = norm && (f != 52'h0);
    end else begin
      e = {4'h0, ex} + adj;
      m = {1'b1, f, 11'h0};
    end
    r.val = {s, e, m};
    return r;
  endfunction

  // Extended into real or long real, round to nearest even.
  // Tiny results flush to signed zero; denormal outputs are not produced.
  function automatic rmsc_narrow_t narrow(input logic [79:0] x, input logic is_long);
    rmsc_narrow_t r;
    logic s;
    logic [14:0] e;
    logic [63:0] m;
    logic [63:0] mn;
    logic [6:0] lz;
    logic found;
    logic [17:0] be;
    logic [17:0] emax;
    logic [52:0] frac;
    logic g;
    logic st;
    logic cy;
    r = '0;
    s = x[79];
    e = x[78:64];
    m = x[63:0];
    emax = is_long ? RMSC_LONG_EMAX : RMSC_SGL_EMAX;
    lz = 7'h0;
    found = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      if (!found) begin
        if (m[i]) begin
          found = 1'b1;
        end else begin
          lz = lz + 7'h1;
        end
      end
    end
    mn = m << lz;
    be = {3'h0, e} - {3'h0, RMSC_EXT_BIAS} + (is_long ? RMSC_LONG_BIAS : RMSC_SGL_BIAS)
         - {11'h0, lz};
    if (is_long) begin
      frac = {1'b0, mn[62:11]};
      g = mn[10];
      st = |mn[9:0];
    end else begin
      frac = {30'h0, mn[62:40]};
      g = mn[39];
      st = |mn[38:0];
    end
    frac = frac + {52'h0, g & (st | frac[0])};
    cy = is_long ? frac[52] : frac[23];
    if (cy) begin
      be = be + 18'h1;
      frac = 53'h0;
    end
    if (e == RMSC_EXT_EMAX) begin
      if (m[62:0] != 63'h0) begin
        r.exc[RMSC_EXC_INV] = !m[62];
        r.val = is_long ? {s, 11'h7ff, 1'b1, m[61:11]} : {32'h0, s, 8'hff, 1'b1, m[61:40]};
      end else begin
        r.val = is_long ? {s, 63'h7ff0000000000000} : {32'h0, s, 31'h7f800000};
      end
    end else if (m == 64'h0) begin
      r.val = is_long ? {s, 63'h0} : {32'h0, s, 31'h0};
    end else if (!be[17] && (be >= emax)) begin
      r.exc[RMSC_EXC_OVF] = 1'b1;
      r.exc[RMSC_EXC_INX] = 1'b1;
      r.val = is_long ? {s, 63'h7ff0000000000000} : {32'h0, s, 31'h7f800000};
    end else if (be[17] || (be == 18'h0)) begin
      r.exc[RMSC_EXC_UNF] = 1'b1;
      r.exc[RMSC_EXC_INX] = 1'b1;
      r.val = is_long ? {s, 63'h0} : {32'h0, s, 31'h0};
    end else begin
      r.exc[RMSC_EXC_INX] = g | st;
      r.val = is_long ? {s, be[10:0], frac[51:0]} : {32'h0, s, be[7:0], frac[22:0]};
    end
    return r;
  endfunction

  // Reserved-operand and signalling check of an extended source
  function automatic rmsc_wide_t ext_check(input logic [79:0] x, input logic norm);
    rmsc_wide_t r;
    r = '0;
    r.val = x;
    if (x[78:64] == RMSC_EXT_EMAX) begin
      r.exc[RMSC_EXC_INV] = (x[62:0] != 63'h0) && !x[62];
      r.val[62] = r.val[62] | (x[62:0] != 63'h0);
    end else begin
      r.rsv = norm && !x[63] && (x[63:0] != 64'h0);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Real move datapath, one cycle from accept to result

  logic ready_q;
  logic accept;
  logic is_long;
  rmsc_wide_t src_w;
  rmsc_narrow_t dst_n;
  logic [79:0] mv_ext;
  logic [95:0] gr_res;
  logic [RMSC_EXC_W-1:0] mv_exc;
  logic mv_rsv;
  logic [RMSC_EXC_W-1:0] unmasked;
  logic mv_fault;
  logic [1:0] grp;

  assign accept = CMD_VALID_I && ready_q;
  assign is_long = (CMD_OP_I == RMSC_OP_LONG);

  always_comb begin
    src_w = '0;
    dst_n = '0;
    mv_ext = CMD_FP_DATA_I;
    gr_res = 96'h0;
    mv_exc = '0;
    mv_rsv = 1'b0;
    grp = RMSC_GRP_REAL;
    case (CMD_OP_I)
      RMSC_OP_REAL, RMSC_OP_LONG: begin
        grp = is_long ? RMSC_GRP_LONG : RMSC_GRP_REAL;
        // Every real move passes through extended form, so no direct path exists
        if (CMD_SRC_FP_I) begin
          src_w = ext_check(CMD_FP_DATA_I, CMD_NORM_MODE_I);
        end else begin
          src_w = widen(CMD_GR_DATA_I[63:0], is_long, CMD_NORM_MODE_I);
        end
        mv_ext = src_w.val;
        dst_n = narrow(src_w.val, is_long);
        gr_res = {32'h0, dst_n.val};
        mv_exc = src_w.exc | (CMD_DST_FP_I ? '0 : dst_n.exc);
        mv_rsv = src_w.rsv;
      end
      RMSC_OP_EXT: begin
        grp = RMSC_GRP_EXT;
        // Pure bit copy: no flags are ever produced here
        mv_ext = CMD_SRC_FP_I ? CMD_FP_DATA_I : CMD_GR_DATA_I[79:0];
        gr_res = {RMSC_EXT_PAD, mv_ext};
      end
      default: begin
        mv_ext = CMD_FP_DATA_I;
      end
    endcase
  end

  assign unmasked = mv_exc & ~CMD_EXC_MASK_I;
  assign mv_fault = mv_rsv || (unmasked != '0);

  logic gr_we_q;
  logic fp_we_q;
  logic [4:0] waddr_q;
  logic [1:0] wcnt_q;
  logic [95:0] gr_wdata_q;
  logic [79:0] fp_wdata_q;
  logic [RMSC_EXC_W-1:0] exc_q;
  logic fault_q;
  logic [RMSC_EXC_W:0] cause_q;

  // Whole group committed in one write, suppressed entirely on a fault
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gr_we_q <= 1'b0;
      fp_we_q <= 1'b0;
      waddr_q <= 5'h0;
      wcnt_q <= 2'h0;
      gr_wdata_q <= 96'h0;
      fp_wdata_q <= 80'h0;
      exc_q <= '0;
      fault_q <= 1'b0;
      cause_q <= '0;
    end else begin
      gr_we_q <= 1'b0;
      fp_we_q <= 1'b0;
      exc_q <= '0;
      fault_q <= 1'b0;
      if (accept && (CMD_OP_I != RMSC_OP_STR)) begin
        waddr_q <= CMD_DST_REG_I;
        wcnt_q <= grp;
        gr_wdata_q <= gr_res;
        fp_wdata_q <= mv_ext;
        if (mv_fault) begin
          fault_q <= 1'b1;
          cause_q <= {mv_rsv, unmasked};
        end else begin
          gr_we_q <= !CMD_DST_FP_I;
          fp_we_q <= CMD_DST_FP_I;
          exc_q <= mv_exc;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // String copy sequencer

  rmsc_state_t state_q;
  logic down_q;
  logic [31:0] rd_addr_q;
  logic [31:0] wr_addr_q;
  logic [31:0] rd_left_q;
  logic [31:0] wr_left_q;
  logic rd_req_q;
  logic wr_req_q;
  logic [RMSC_BYTE_W-1:0] wr_data_q;
  logic str_start;
  logic push;
  logic pop;
  logic finish;
  logic [1:0] cnt_q;
  logic wp_q;
  logic rp_q;
  logic [RMSC_BYTE_W-1:0] buf_q [RMSC_BUF_DEPTH];

  assign str_start = accept && (CMD_OP_I == RMSC_OP_STR);
  assign push = rd_req_q && MEM_RD_ACK_I;
  assign pop = (state_q == RMSC_ST_RUN) && !wr_req_q && (cnt_q != 2'h0);
  assign finish = wr_req_q && MEM_WR_ACK_I && (wr_left_q == 32'h1);

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= RMSC_ST_IDLE;
      ready_q <= RMSC_RST_READY;
      down_q <= 1'b0;
    end else begin
      case (state_q)
        RMSC_ST_IDLE: begin
          // A zero count finishes at once without touching memory
          if (str_start && (CMD_LEN_I != 32'h0)) begin
            state_q <= RMSC_ST_RUN;
            ready_q <= 1'b0;
            down_q <= (CMD_SRC_ADDR_I <= CMD_DST_ADDR_I);
          end
        end
        RMSC_ST_RUN: begin
          if (finish) begin
            state_q <= RMSC_ST_IDLE;
            ready_q <= 1'b1;
          end
        end
        default: begin
          state_q <= RMSC_ST_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // Read side; at most one read outstanding so the buffer never overflows
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_req_q <= 1'b0;
      rd_addr_q <= 32'h0;
      rd_left_q <= 32'h0;
    end else if (str_start) begin
      rd_addr_q <= (CMD_SRC_ADDR_I <= CMD_DST_ADDR_I) ?
                   CMD_SRC_ADDR_I + CMD_LEN_I - 32'h1 : CMD_SRC_ADDR_I;
      rd_left_q <= CMD_LEN_I;
    end else if (push) begin
      rd_req_q <= 1'b0;
      rd_addr_q <= down_q ? rd_addr_q - 32'h1 : rd_addr_q + 32'h1;
      rd_left_q <= rd_left_q - 32'h1;
    end else if ((state_q == RMSC_ST_RUN) && !rd_req_q && (rd_left_q != 32'h0) &&
                 (cnt_q < RMSC_BUF_DEPTH)) begin
      rd_req_q <= 1'b1;
    end
  end

  // Two-entry buffer between reads and writes; reads are held off while it is full or while a read is outstanding
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cnt_q <= 2'h0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (push) begin
        buf_q[wp_q] <= MEM_RD_DATA_I;
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Write side
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_req_q <= 1'b0;
      wr_addr_q <= 32'h0;
      wr_left_q <= 32'h0;
      wr_data_q <= '0;
    end else if (str_start) begin
      wr_addr_q <= (CMD_SRC_ADDR_I <= CMD_DST_ADDR_I) ?
                   CMD_DST_ADDR_I + CMD_LEN_I - 32'h1 : CMD_DST_ADDR_I;
      wr_left_q <= CMD_LEN_I;
    end else if (wr_req_q && MEM_WR_ACK_I) begin
      wr_req_q <= 1'b0;
      wr_addr_q <= down_q ? wr_addr_q - 32'h1 : wr_addr_q + 32'h1;
      wr_left_q <= wr_left_q - 32'h1;
    end else if (pop) begin
      wr_req_q <= 1'b1;
      wr_data_q <= buf_q[rp_q];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion pulse

  logic done_q;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      done_q <= 1'b0;
    end else begin
      done_q <= finish || (str_start && (CMD_LEN_I == 32'h0)) ||
                (accept && (CMD_OP_I != RMSC_OP_STR) && !mv_fault);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign CMD_READY_O = ready_q;
  assign GR_WE_O = gr_we_q;
  assign GR_WADDR_O = waddr_q;
  assign GR_WCNT_O = wcnt_q;
  assign GR_WDATA_O = gr_wdata_q;
  assign FP_WE_O = fp_we_q;
  assign FP_WADDR_O = waddr_q;
  assign FP_WDATA_O = fp_wdata_q;
  assign EXC_O = exc_q;
  assign FAULT_O = fault_q;
  assign FAULT_CAUSE_O = cause_q;
  assign DONE_O = done_q;
  assign MEM_RD_REQ_O = rd_req_q;
  assign MEM_RD_ADDR_O = rd_addr_q;
  assign MEM_WR_REQ_O = wr_req_q;
  assign MEM_WR_ADDR_O = wr_addr_q;
  assign MEM_WR_DATA_O = wr_data_q;

endmodule

// ===== tb/rmsc_mem_model.sv
`timescale 1ns/1ps
module rmsc_mem_model
  import rmsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] dly_i,
  input wire logic rd_req_i,
  input wire logic [31:0] rd_addr_i,
  output logic rd_ack_o,
  output logic [RMSC_BYTE_W-1:0] rd_data_o,
  input wire logic wr_req_i,
  input wire logic [31:0] wr_addr_i,
  input wire logic [RMSC_BYTE_W-1:0] wr_data_i,
  output logic wr_ack_o
);
  logic [7:0] mem [0:255];
  logic [3:0] rcnt_q;
  logic [3:0] wcnt_q;
  //////////////////////////////////////////////////////////////////////////
  // Read data toggles outside ack so a stale byte can never look right
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ack_o <= 1'b0;
      rd_data_o <= 8'h00;
      rcnt_q <= 4'h0;
    end else if (rd_req_i && !rd_ack_o && rcnt_q >= dly_i) begin
      rd_ack_o <= 1'b1;
      rd_data_o <= mem[rd_addr_i[7:0]];
      rcnt_q <= 4'h0;
    end else begin
      rd_ack_o <= 1'b0;
      rd_data_o <= ~rd_data_o;
      rcnt_q <= (rd_req_i && !rd_ack_o) ? rcnt_q + 4'h1 : 4'h0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Writes stall for dly_i cycles to fill the design's buffer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ack_o <= 1'b0;
      wcnt_q <= 4'h0;
    end else if (wr_req_i && !wr_ack_o && wcnt_q >= dly_i) begin
      wr_ack_o <= 1'b1;
      wcnt_q <= 4'h0;
    end else begin
      wr_ack_o <= 1'b0;
      wcnt_q <= (wr_req_i && !wr_ack_o) ? wcnt_q + 4'h1 : 4'h0;
    end
  end
  // Plain always: the bench also preloads this array
  always @(posedge clk_i) begin
    if (rst_n_i && wr_req_i && !wr_ack_o && wcnt_q >= dly_i) begin
      mem[wr_addr_i[7:0]] <= wr_data_i;
    end
  end
endmodule

// ===== tb/rmsc_monitor.sv
`timescale 1ns/1ps
module rmsc_monitor
  import rmsc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CMD_VALID_I,
  input wire logic CMD_READY_O,
  input wire logic [1:0] CMD_OP_I,
  input wire logic CMD_SRC_FP_I,
  input wire logic CMD_DST_FP_I,
  input wire logic [95:0] CMD_GR_DATA_I,
  input wire logic CMD_NORM_MODE_I,
  input wire logic [31:0] CMD_LEN_I,
  input wire logic GR_WE_O,
  input wire logic [1:0] GR_WCNT_O,
  input wire logic [95:0] GR_WDATA_O,
  input wire logic FP_WE_O,
  input wire logic [79:0] FP_WDATA_O,
  input wire logic [RMSC_EXC_W-1:0] EXC_O,
  input wire logic FAULT_O,
  input wire logic [RMSC_EXC_W:0] FAULT_CAUSE_O,
  input wire logic DONE_O,
  input wire logic MEM_WR_REQ_O,
  input wire logic [31:0] MEM_WR_ADDR_O,
  input wire logic [RMSC_BYTE_W-1:0] MEM_WR_DATA_O,
  input wire logic MEM_WR_ACK_I
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic acc;
  logic [79:0] gr_lo_q;
  assign acc = CMD_VALID_I && CMD_READY_O;
  always_ff @(posedge CLK_I) begin
    gr_lo_q <= CMD_GR_DATA_I[79:0];
  end
  //////////////////////////////////////////////////////////////////////////
  ext_trunc_a: assert property (
    acc && CMD_OP_I == RMSC_OP_EXT && !CMD_SRC_FP_I && CMD_DST_FP_I
    |=> FP_WE_O && FP_WDATA_O == gr_lo_q) else $error("ext load wrong");
  ext_pad_a: assert property (
    acc && CMD_OP_I == RMSC_OP_EXT && !CMD_DST_FP_I |=> GR_WE_O
    && GR_WCNT_O == RMSC_GRP_EXT && GR_WDATA_O[95:80] == RMSC_EXT_PAD) else $error("ext pad");
  ext_quiet_a: assert property (
    acc && CMD_OP_I == RMSC_OP_EXT |=> !FAULT_O && EXC_O == '0) else $error("ext raised");
  long_group_a: assert property (
    acc && CMD_OP_I == RMSC_OP_LONG && !CMD_DST_FP_I
    |=> FAULT_O || (GR_WE_O && GR_WCNT_O == RMSC_GRP_LONG)) else $error("long group");
  rsv_fault_a: assert property (
    acc && CMD_OP_I == RMSC_OP_REAL && !CMD_SRC_FP_I && CMD_NORM_MODE_I
    && CMD_GR_DATA_I[30:23] == 8'h00 && CMD_GR_DATA_I[22:0] != 23'h0
    |=> FAULT_O && FAULT_CAUSE_O[RMSC_EXC_W]) else $error("no reserved fault");
  fault_atomic_a: assert property (
    FAULT_O |-> !GR_WE_O && !FP_WE_O && !DONE_O) else $error("fault wrote");
  fault_cause_a: assert property (
    FAULT_O |-> FAULT_CAUSE_O != '0) else $error("empty cause");
  exc_masked_a: assert property (
    (|EXC_O) |-> GR_WE_O || FP_WE_O) else $error("flags without write");
  real_answer_a: assert property (
    acc && CMD_OP_I != RMSC_OP_STR |=> GR_WE_O || FP_WE_O || FAULT_O) else $error("no answer");
  wr_hold_a: assert property (
    MEM_WR_REQ_O && !MEM_WR_ACK_I |=> MEM_WR_REQ_O && $stable(MEM_WR_ADDR_O)
    && $stable(MEM_WR_DATA_O)) else $error("write dropped");
  str_busy_a: assert property (
    acc && CMD_OP_I == RMSC_OP_STR && CMD_LEN_I != '0 |-> ##2 !CMD_READY_O) else $error("not busy");
endmodule
bind rmsc_top rmsc_monitor rmsc_monitor_inst (.CLK_I, .RST_N_I, .CMD_VALID_I, .CMD_READY_O,
  .CMD_OP_I, .CMD_SRC_FP_I, .CMD_DST_FP_I, .CMD_GR_DATA_I, .CMD_NORM_MODE_I, .CMD_LEN_I,
  .GR_WE_O, .GR_WCNT_O, .GR_WDATA_O, .FP_WE_O, .FP_WDATA_O, .EXC_O, .FAULT_O, .FAULT_CAUSE_O,
  .DONE_O, .MEM_WR_REQ_O, .MEM_WR_ADDR_O, .MEM_WR_DATA_O, .MEM_WR_ACK_I);

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, (e), (g)); end end
module tb_top
  import rmsc_pkg::*;
;
  logic CLK_I, RST_N_I, CMD_VALID_I, CMD_SRC_FP_I, CMD_DST_FP_I, CMD_NORM_MODE_I;
  logic [1:0] CMD_OP_I, GR_WCNT_O;
  logic [4:0] CMD_DST_REG_I, GR_WADDR_O, FP_WADDR_O, FAULT_CAUSE_O;
  logic [95:0] CMD_GR_DATA_I, GR_WDATA_O;
  logic [79:0] CMD_FP_DATA_I, FP_WDATA_O;
  logic [3:0] CMD_EXC_MASK_I, EXC_O, DLY;
  logic [31:0] CMD_SRC_ADDR_I, CMD_DST_ADDR_I, CMD_LEN_I, MEM_RD_ADDR_O, MEM_WR_ADDR_O;
  logic CMD_READY_O, GR_WE_O, FP_WE_O, FAULT_O, DONE_O;
  logic MEM_RD_REQ_O, MEM_RD_ACK_I, MEM_WR_REQ_O, MEM_WR_ACK_I;
  logic [7:0] MEM_RD_DATA_I, MEM_WR_DATA_O;
  int n_fail, num_checks;
  int cyc = 0;
  rmsc_top rmsc_top_inst (.CLK_I, .RST_N_I, .CMD_VALID_I, .CMD_READY_O, .CMD_OP_I,
    .CMD_SRC_FP_I, .CMD_DST_FP_I, .CMD_DST_REG_I, .CMD_GR_DATA_I, .CMD_FP_DATA_I,
    .CMD_NORM_MODE_I, .CMD_EXC_MASK_I, .CMD_SRC_ADDR_I, .CMD_DST_ADDR_I, .CMD_LEN_I,
    .GR_WE_O, .GR_WADDR_O, .GR_WCNT_O, .GR_WDATA_O, .FP_WE_O, .FP_WADDR_O, .FP_WDATA_O,
    .EXC_O, .FAULT_O, .FAULT_CAUSE_O, .DONE_O, .MEM_RD_REQ_O, .MEM_RD_ADDR_O, .MEM_RD_ACK_I,
    .MEM_RD_DATA_I, .MEM_WR_REQ_O, .MEM_WR_ADDR_O, .MEM_WR_DATA_O, .MEM_WR_ACK_I);
  rmsc_mem_model rmsc_mem_model_inst (.clk_i(CLK_I), .rst_n_i(RST_N_I), .dly_i(DLY),
    .rd_req_i(MEM_RD_REQ_O), .rd_addr_i(MEM_RD_ADDR_O), .rd_ack_o(MEM_RD_ACK_I),
    .rd_data_o(MEM_RD_DATA_I), .wr_req_i(MEM_WR_REQ_O), .wr_addr_i(MEM_WR_ADDR_O),
    .wr_data_i(MEM_WR_DATA_O), .wr_ack_o(MEM_WR_ACK_I));
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  // Whole run needs well under 2000 cycles
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // One real move; returns in the cycle of the one-cycle answer
  task automatic mv(input logic [1:0] op, input logic sf, input logic df,
      input logic [95:0] gr, input logic [79:0] fp, input logic nm, input logic [3:0] mk);
    @(posedge CLK_I);
    {CMD_VALID_I, CMD_OP_I, CMD_SRC_FP_I, CMD_DST_FP_I} <= {1'b1, op, sf, df};
    {CMD_GR_DATA_I, CMD_FP_DATA_I, CMD_NORM_MODE_I, CMD_EXC_MASK_I} <= {gr, fp, nm, mk};
    @(posedge CLK_I);
    CMD_VALID_I <= 1'b0;
    #1;
  endtask
  task automatic t_ext();
    mv(RMSC_OP_EXT, 1'b0, 1'b1, 96'hbeef_4000_c000_0000_0000_0001, '0, 1'b1, 4'h0);
    `CHK("ext in", 80'h4000_c000_0000_0000_0001, FP_WDATA_O)
    `CHK("ext in flags", 7'h50, {FP_WE_O, FAULT_O, DONE_O, EXC_O})
    `CHK("waddr", 5'h05, FP_WADDR_O)
    mv(RMSC_OP_EXT, 1'b1, 1'b0, '0, 80'h7fff_a000_0000_0000_0000, 1'b1, 4'h0);
    `CHK("ext out", {16'h0000, 80'h7fff_a000_0000_0000_0000}, GR_WDATA_O)
    `CHK("ext out flags", 8'he0, {GR_WE_O, GR_WCNT_O, FAULT_O, EXC_O})
  endtask
  // Real to long real takes two moves through an extended value
  task automatic t_long();
    mv(RMSC_OP_REAL, 1'b0, 1'b1, {64'h0, 32'h3fc0_0000}, '0, 1'b0, 4'hf);
    `CHK("real to ext", 80'h3fff_c000_0000_0000_0000, FP_WDATA_O)
    mv(RMSC_OP_LONG, 1'b1, 1'b0, '0, 80'h3fff_c000_0000_0000_0000, 1'b0, 4'hf);
    `CHK("ext to long", 64'h3ff8_0000_0000_0000, GR_WDATA_O[63:0])
    `CHK("long cnt", RMSC_GRP_LONG, GR_WCNT_O)
    `CHK("gr waddr", 5'h05, GR_WADDR_O)
    mv(RMSC_OP_LONG, 1'b0, 1'b1, {32'h0, 64'hc000_0000_0000_0000}, '0, 1'b0, 4'hf);
    `CHK("long to ext", 80'hc000_8000_0000_0000_0000, FP_WDATA_O)
  endtask
  task automatic t_exc();
    logic [79:0] src [4];
    logic [31:0] res [4];
    logic [3:0] fl [4];
    src = '{80'h7ffe_8000_0000_0000_0000, 80'h0001_8000_0000_0000_0000,
      80'h3fff_8000_0000_0000_0001, 80'h7fff_a000_0000_0000_0000};
    res = '{32'h7f80_0000, 32'h0000_0000, 32'h3f80_0000, 32'h7fe0_0000};
    fl = '{4'h9, 4'ha, 4'h8, 4'h4};
    for (int k = 0; k < 4; k++) begin
      mv(RMSC_OP_REAL, 1'b1, 1'b0, '0, src[k], 1'b0, 4'hf);
      `CHK("real res", res[k], GR_WDATA_O[31:0])
      `CHK("real exc", fl[k], EXC_O)
    end
    // Signalling single from a general register is quieted on the way in
    mv(RMSC_OP_REAL, 1'b0, 1'b1, {64'h0, 32'h7fa0_0000}, '0, 1'b0, 4'hf);
    `CHK("signalling_not_a_number in", {4'h4, 80'h7fff_e000_0000_0000_0000}, {EXC_O, FP_WDATA_O})
  endtask
  task automatic t_fault();
    mv(RMSC_OP_REAL, 1'b1, 1'b0, '0, 80'h7ffe_8000_0000_0000_0000, 1'b0, 4'he);
    `CHK("ovf fault", 8'h81, {FAULT_O, GR_WE_O, DONE_O, FAULT_CAUSE_O})
    mv(RMSC_OP_REAL, 1'b0, 1'b1, {64'h0, 32'h0000_0001}, '0, 1'b1, 4'hf);
    `CHK("rsv fault", 8'h90, {FAULT_O, FP_WE_O, DONE_O, FAULT_CAUSE_O})
    mv(RMSC_OP_REAL, 1'b0, 1'b1, {64'h0, 32'h0000_0001}, '0, 1'b0, 4'hf);
    `CHK("no rsv", 2'b01, {FAULT_O, FP_WE_O})
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Overlapping, disjoint and empty copies; expected image built by the documented loop order
  task automatic t_str(input logic [31:0] s, input logic [31:0] d, input logic [31:0] n,
      input logic [3:0] dly);
    logic [7:0] exp_m [0:255];
    int k;
    for (k = 0; k < 256; k++) begin
      rmsc_mem_model_inst.mem[k] = k[7:0] ^ 8'h5a;
      exp_m[k] = k[7:0] ^ 8'h5a;
    end
    if (s <= d) begin
      for (k = 1; k <= n; k++) exp_m[d + n - k] = exp_m[s + n - k];
    end else begin
      for (k = 0; k < n; k++) exp_m[d + k] = exp_m[s + k];
    end
    @(posedge CLK_I);
    DLY <= dly;
    {CMD_VALID_I, CMD_OP_I} <= {1'b1, RMSC_OP_STR};
    {CMD_SRC_ADDR_I, CMD_DST_ADDR_I, CMD_LEN_I} <= {s, d, n};
    @(posedge CLK_I);
    CMD_VALID_I <= 1'b0;
    #1;
    if (n == 32'h0) begin
      `CHK("empty copy", 2'b11, {DONE_O, CMD_READY_O})
    end else begin
      @(posedge CLK_I);
      #1;
      `CHK("busy", 1'b0, CMD_READY_O)
      k = 0;
      while (DONE_O !== 1'b1 && k < 2000) begin
        @(posedge CLK_I);
        #1;
        k++;
      end
      `CHK("str done", 1'b1, DONE_O)
    end
    for (k = 0; k < 256; k++) `CHK("mem", exp_m[k], rmsc_mem_model_inst.mem[k])
  endtask
  initial begin
    {RST_N_I, CMD_VALID_I, CMD_OP_I, CMD_SRC_FP_I, CMD_DST_FP_I, CMD_NORM_MODE_I} = '0;
    {CMD_GR_DATA_I, CMD_FP_DATA_I, CMD_EXC_MASK_I} = '0;
    {CMD_SRC_ADDR_I, CMD_DST_ADDR_I, CMD_LEN_I} = '0;
    CMD_DST_REG_I = 5'h05;
    DLY = 4'h0;
    n_fail = 0;
    num_checks = 0;
    repeat (10) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    t_ext();
    t_long();
    t_exc();
    t_fault();
    t_str(32'd10, 32'd13, 32'd6, 4'h2);
    t_str(32'd20, 32'd17, 32'd5, 4'h0);
    t_str(32'd40, 32'd200, 32'd1, 4'h3);
    t_str(32'd30, 32'd30, 32'd0, 4'h0);
    end_sim();
  end
endmodule
